// ==== logic/xps_pkg.sv ====
// constants and carrier types for the crosspoint serial configuration block
// assumes a single 50 MHz system clock samples every serial pin
package xps_pkg;

  // ==========================================================================
  // geometry
  localparam int XPS_WORD_W = 16;
  localparam int XPS_NUM_OUT = 16;
  localparam int XPS_SRC_W = 5;
  localparam int XPS_DST_W = 4;
  localparam int XPS_BANK_SIZE = 4;
  localparam int XPS_SYNC_W = 4;

  // ==========================================================================
  // pin positions inside the synchroniser vector
  localparam int XPS_PIN_SCLK = 0;
  localparam int XPS_PIN_DIN = 1;
  localparam int XPS_PIN_STROBE = 2;
  localparam int XPS_PIN_RESET = 3;

  // ==========================================================================
  // field positions of the command word
  localparam int XPS_CMD_HI = 15;
  localparam int XPS_CMD_LO = 13;
  localparam int XPS_SRC_HI = 12;
  localparam int XPS_SRC_LO = 8;
  localparam int XPS_DST_HI = 3;
  localparam int XPS_DST_LO = 0;
  localparam int XPS_BANK_HI = 9;
  localparam int XPS_BANK_LO = 8;
  localparam int XPS_BCAST_EN_BIT = 0;
  localparam int XPS_CLAMP_BIT = 9;
  localparam int XPS_POWER_BIT = 1;
  localparam int XPS_GLOBAL_BIT = 0;

  // ==========================================================================
  // command codes and reset values
  localparam logic [2:0] XPS_CMD_ROUTE = 3'h0;
  localparam logic [2:0] XPS_CMD_ENABLE = 3'h1;
  localparam logic [2:0] XPS_CMD_GAIN = 3'h2;
  localparam logic [2:0] XPS_CMD_BCAST = 3'h3;
  localparam logic [2:0] XPS_CMD_CONTROL = 3'h7;
  localparam logic [15:0] XPS_WORD_RST = 16'h0000;
  localparam logic [15:0] XPS_EN_RST = 16'h0000;
  localparam logic [15:0] XPS_GAIN_RST = 16'h0000;
  localparam logic [4:0] XPS_SRC_RST = 5'h00;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic clamp_en;
    logic operational;
    logic global_en;
  } xps_ctrl_s;

  typedef struct packed {
    logic active;
    logic [4:0] source;
  } xps_bcast_s;

  typedef logic [15:0][4:0] xps_route_t;

endpackage

// ==== logic/xps_serial_cfg.sv ====
// serial configuration front end of a 32 by 16 video crosspoint
// assumes serial clock, data, strobe and reset pins are asynchronous to
// clock and that the serial clock is well below a quarter of clock's rate
`timescale 1ns/1ps

module xps_serial_cfg (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic load_strobe,
  input wire logic reset_pin,
  output logic chain_out,
  output xps_pkg::xps_route_t route_map,
  output logic [15:0] drive_en,
  output logic [15:0] gain_x2,
  output xps_pkg::xps_ctrl_s ctrl,
  output xps_pkg::xps_bcast_s bcast
);
  import xps_pkg::*;

  // ==========================================================================
  // pin synchronisers
  logic [XPS_SYNC_W-1:0] pins_raw;
  logic [XPS_SYNC_W-1:0] sync1_reg;
  logic [XPS_SYNC_W-1:0] sync2_reg;
  logic [XPS_SYNC_W-1:0] prev_reg;
  logic sclk_rise;
  logic sclk_fall;
  logic strobe_rise;
  logic din;
  logic dev_reset;
  logic clear_cfg;

  assign pins_raw[XPS_PIN_SCLK] = serial_clk;
  assign pins_raw[XPS_PIN_DIN] = serial_in;
  assign pins_raw[XPS_PIN_STROBE] = load_strobe;
  assign pins_raw[XPS_PIN_RESET] = reset_pin;

  // two flops per pin; only sync2 and its delayed copy feed logic
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // data and clock share equal synchroniser delay, so setup is kept
  assign din = sync2_reg[XPS_PIN_DIN];
  assign sclk_rise = sync2_reg[XPS_PIN_SCLK] & ~prev_reg[XPS_PIN_SCLK];
  assign sclk_fall = ~sync2_reg[XPS_PIN_SCLK] & prev_reg[XPS_PIN_SCLK];
  assign strobe_rise = sync2_reg[XPS_PIN_STROBE] & ~prev_reg[XPS_PIN_STROBE];
  assign dev_reset = sync2_reg[XPS_PIN_RESET];
  assign clear_cfg = !rst_n || dev_reset;

  // ==========================================================================
  // shift register and chain output
  logic [15:0] shift_reg;
  logic [15:0] shift_next;

  assign shift_next = {din, shift_reg[15:1]};

  always_ff @(posedge clock) begin
    if (clear_cfg) begin
      shift_reg <= XPS_WORD_RST;
    end else if (sclk_rise) begin
      shift_reg <= shift_next;
    end
  end

  // chain delay and falling edge
  // a bit reaches shift_reg[0] fifteen rises after entry; the next fall
  // puts it out, giving the half-clock extra delay that chaining needs
  always_ff @(posedge clock) begin
    if (clear_cfg) begin
      chain_out <= 1'b0;
    end else if (sclk_fall) begin
      chain_out <= shift_reg[0];
    end
  end

  // ==========================================================================
  // command decode
  logic [2:0] cmd;
  logic [4:0] word_src;
  logic [3:0] word_dst;
  logic [1:0] word_bank;
  logic latch_route;
  logic latch_enable;
  logic latch_gain;
  logic latch_bcast;
  logic latch_ctrl;

  assign cmd = shift_reg[XPS_CMD_HI:XPS_CMD_LO];
  assign word_src = shift_reg[XPS_SRC_HI:XPS_SRC_LO];
  assign word_dst = shift_reg[XPS_DST_HI:XPS_DST_LO];
  assign word_bank = shift_reg[XPS_BANK_HI:XPS_BANK_LO];
  // codes 4 to 6 match no strobe term
  assign latch_route = strobe_rise && (cmd == XPS_CMD_ROUTE);
  assign latch_enable = strobe_rise && (cmd == XPS_CMD_ENABLE);
  assign latch_gain = strobe_rise && (cmd == XPS_CMD_GAIN);
  assign latch_bcast = strobe_rise && (cmd == XPS_CMD_BCAST);
  assign latch_ctrl = strobe_rise && (cmd == XPS_CMD_CONTROL);

  // ==========================================================================
  // configuration store
  xps_route_t route_reg;
  logic [15:0] en_reg;
  logic [15:0] gain_reg;
  xps_ctrl_s ctrl_reg;
  xps_bcast_s bcast_reg;

  // per-output routing, enable and gain slices
  for (genvar k = 0; k < XPS_NUM_OUT; k++) begin : g_out
    localparam logic [3:0] K_DST = 4'(k);
    localparam logic [1:0] K_BANK = 2'(k / XPS_BANK_SIZE);
    localparam int K_BIT = 2 * (k % XPS_BANK_SIZE);

    always_ff @(posedge clock) begin
      if (clear_cfg) begin
        route_reg[k] <= XPS_SRC_RST;
      end else if (latch_route && word_dst == K_DST) begin
        route_reg[k] <= word_src;
      end
    end

    always_ff @(posedge clock) begin
      if (clear_cfg) begin
        en_reg[k] <= XPS_EN_RST[k];
      end else if (latch_enable && word_bank == K_BANK) begin
        en_reg[k] <= shift_reg[K_BIT];
      end
    end

    always_ff @(posedge clock) begin
      if (clear_cfg) begin
        gain_reg[k] <= XPS_GAIN_RST[k];
      end else if (latch_gain && word_bank == K_BANK) begin
        gain_reg[k] <= shift_reg[K_BIT];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (clear_cfg) begin
      bcast_reg <= '0;
    end else if (latch_bcast) begin
      bcast_reg.active <= shift_reg[XPS_BCAST_EN_BIT];
      bcast_reg.source <= word_src;
    end
  end

  always_ff @(posedge clock) begin
    if (clear_cfg) begin
      ctrl_reg <= '0;
    end else if (latch_ctrl) begin
      ctrl_reg.clamp_en <= shift_reg[XPS_CLAMP_BIT];
      ctrl_reg.operational <= shift_reg[XPS_POWER_BIT];
      ctrl_reg.global_en <= shift_reg[XPS_GLOBAL_BIT];
    end
  end

  // ==========================================================================
  // registered outputs, one cycle behind the store
  // route words sent during broadcast still land in the store; the host
  // is expected to avoid that, and nothing here guards against it
  always_ff @(posedge clock) begin
    if (clear_cfg) begin
      route_map <= '0;
    end else begin
      for (int i = 0; i < XPS_NUM_OUT; i++) begin
        route_map[i] <= bcast_reg.active ? bcast_reg.source : route_reg[i];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (clear_cfg) begin
      drive_en <= '0;
    end else begin
      drive_en <= en_reg & {XPS_NUM_OUT{ctrl_reg.global_en}};
    end
  end

  // gain, control and broadcast copies for the analog side
  always_ff @(posedge clock) begin
    if (clear_cfg) begin
      gain_x2 <= '0;
      ctrl <= '0;
      bcast <= '0;
    end else begin
      gain_x2 <= gain_reg;
      ctrl <= ctrl_reg;
      bcast <= bcast_reg;
    end
  end

  // ==========================================================================
  // checks
  logic all_bcast;
  logic all_store;
  logic [3:0] word_bits;

  // helper: the four alternate bank bits, highest output first
  assign word_bits = {shift_reg[6], shift_reg[4], shift_reg[2], shift_reg[0]};

  // helper: every output shows the broadcast source, or the store
  always_comb begin
    all_bcast = 1'b1;
    all_store = 1'b1;
    for (int i = 0; i < XPS_NUM_OUT; i++) begin
      if (route_map[i] != bcast_reg.source) begin
        all_bcast = 1'b0;
      end
      if (route_map[i] != route_reg[i]) begin
        all_store = 1'b0;
      end
    end
  end

  sequence seq_route_latch;
    latch_route && !dev_reset;
  endsequence

  sequence seq_bcast_off;
    latch_bcast && !shift_reg[XPS_BCAST_EN_BIT] && !dev_reset;
  endsequence

  sequence seq_bcast_on;
    latch_bcast && shift_reg[XPS_BCAST_EN_BIT] && !dev_reset;
  endsequence

  chk_shift_entry: assert property (
    @(posedge clock) disable iff (!rst_n)
    sclk_rise && !dev_reset |=> shift_reg == {$past(din),
      $past(shift_reg[15:1])})
    else $error("shift register did not take the serial bit");

  chk_shift_strobe_high: assert property (
    @(posedge clock) disable iff (!rst_n)
    sclk_rise && sync2_reg[XPS_PIN_STROBE] && !dev_reset
      |=> shift_reg[15] == $past(din))
    else $error("shift stalled while the strobe was high");

  chk_chain_delay: assert property (
    @(posedge clock) disable iff (!rst_n)
    sclk_fall && !dev_reset |=> chain_out == $past(shift_reg[0]))
    else $error("chain output missed the delayed bit");

  chk_route_apply: assert property (
    @(posedge clock) disable iff (!rst_n)
    seq_route_latch |=> route_reg[$past(word_dst)] == $past(word_src))
    else $error("route word did not update its output");

  chk_enable_bank: assert property (
    @(posedge clock) disable iff (!rst_n)
    latch_enable && !dev_reset |=>
      en_reg[{$past(word_bank), 2'b00} +: 4] == $past(word_bits))
    else $error("enable word missed its bank");

  chk_gain_bank: assert property (
    @(posedge clock) disable iff (!rst_n)
    latch_gain && !dev_reset |=>
      gain_reg[{$past(word_bank), 2'b00} +: 4] == $past(word_bits))
    else $error("gain word missed its bank");

  chk_drive_gate: assert property (
    @(posedge clock) disable iff (!rst_n)
    !ctrl_reg.global_en |=> drive_en == 16'h0000)
    else $error("output driven without global enable");

  chk_bcast_all: assert property (
    @(posedge clock) disable iff (!rst_n)
    seq_bcast_on ##1 !latch_bcast && !dev_reset |=> all_bcast)
    else $error("broadcast source not on every output");

  chk_bcast_restore: assert property (
    @(posedge clock) disable iff (!rst_n)
    seq_bcast_off ##1 !latch_route && !dev_reset |=> all_store)
    else $error("routing not restored after broadcast");

  chk_undef_ignored: assert property (
    @(posedge clock) disable iff (!rst_n)
    strobe_rise && cmd[2] && !(&cmd) && !dev_reset
      |=> $stable(en_reg) && $stable(gain_reg) && $stable(ctrl_reg)
        && $stable(bcast_reg) && $stable(route_reg))
    else $error("undefined command altered configuration");

  chk_no_strobe_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    !strobe_rise && !dev_reset |=> $stable(en_reg) && $stable(gain_reg)
      && $stable(route_reg) && $stable(bcast_reg) && $stable(ctrl_reg))
    else $error("configuration changed without a strobe");

  chk_pin_reset: assert property (
    @(posedge clock) disable iff (!rst_n)
    dev_reset |=> en_reg == 16'h0000 && !ctrl_reg.operational ##1
      drive_en == 16'h0000)
    else $error("pin reset left an output enabled or device running");

endmodule

// ==== verification/crosspoint_serial_config_tb.sv ====
// self-checking bench for the crosspoint serial configuration block
// assumes the host model file is compiled before this one
`timescale 1ns/1ps

module crosspoint_serial_config_tb;
  import xps_pkg::*;
  // ==========================================================================
  // signals and counters
  logic clock = 1'b0;
  logic rst_n;
  logic reset_pin;
  logic serial_clk, serial_in, load_strobe, chain_out;
  xps_route_t route_map, exp_route;
  logic [15:0] drive_en, gain_x2, exp_en, exp_gain;
  xps_ctrl_s ctrl;
  xps_bcast_s bcast;
  int failures = 0;
  int compares = 0;

  // 50 MHz system clock
  always #10 clock = ~clock;

  xps_serial_cfg xps_serial_cfg_i (.clock(clock), .rst_n(rst_n),
    .serial_clk(serial_clk), .serial_in(serial_in),
    .load_strobe(load_strobe), .reset_pin(reset_pin),
    .chain_out(chain_out), .route_map(route_map), .drive_en(drive_en),
    .gain_x2(gain_x2), .ctrl(ctrl), .bcast(bcast));

  xps_host_model xps_host_model_i (.clock(clock), .serial_clk(serial_clk),
    .serial_in(serial_in), .load_strobe(load_strobe),
    .chain_out(chain_out));

  // ==========================================================================
  // helpers
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // shift one word and latch it
  task automatic cmd(input logic [15:0] w);
    xps_host_model_i.shift_word(w);
    xps_host_model_i.latch();
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic final_report();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // watchdog: the whole sequence needs about 80 us
  initial begin
    #1000000;
    failures++;
    final_report();
  end

  // ==========================================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    reset_pin = 1'b0;
    exp_route = '0;
    exp_en = 16'h0000;
    exp_gain = 16'h0000;
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    repeat (5) @(negedge clock);
    check(drive_en, 16'h0000);
    check(ctrl, 3'b000);
    check(route_map, exp_route);
    end_test("reset");
    cmd(16'he203);
    check(ctrl, 3'b111);
    // walk every bank: bits 6 and 0 enable, bits 6 and 4 gain
    for (int k = 0; k < 4; k++) begin
      cmd(16'h2041 | 16'(k) << 8);
      exp_en = exp_en | 16'h0009 << (4 * k);
      check(drive_en, exp_en);
      cmd(16'h4050 | 16'(k) << 8);
      exp_gain = exp_gain | 16'h000c << (4 * k);
      check(gain_x2, exp_gain);
    end
    cmd(16'he002);
    check(drive_en, 16'h0000);
    check(ctrl, 3'b010);
    cmd(16'he203);
    check(drive_en, exp_en);
    end_test("enable_gain");
    // broadcast stays off while routes are written
    // two outputs share source 31, one takes source 3
    for (int d = 5; d < 10; d += 2) begin
      exp_route[d] = (d == 7) ? 5'h03 : 5'h1f;
      cmd({3'h0, exp_route[d], 4'h0, 4'(d)});
      check(route_map, exp_route);
    end
    cmd(16'h6a01);
    check(route_map, {16{5'h0a}});
    check(bcast, 6'h2a);
    cmd(16'h6a00);
    check(route_map, exp_route);
    check(bcast.active, 1'b0);
    end_test("route_broadcast");
    for (int c = 4; c < 7; c++) begin
      cmd({3'(c), 13'h1f0f});
      check(route_map, exp_route);
      check({drive_en, gain_x2, ctrl}, {exp_en, exp_gain, 3'b111});
    end
    end_test("undefined");
    // strobe high while shifting, then low: nothing may change yet
    xps_host_model_i.strobe(1'b1);
    xps_host_model_i.shift_word(16'h020c);
    check(xps_host_model_i.chain_seen, 16'hdf0f);
    xps_host_model_i.strobe(1'b0);
    check(route_map, exp_route);
    xps_host_model_i.latch();
    exp_route[12] = 5'h02;
    check(route_map, exp_route);
    end_test("strobe_chain");
    // two words, one strobe: the first moves on, only the second lands
    xps_host_model_i.shift_word(16'h1103);
    xps_host_model_i.shift_word(16'h1500);
    check(xps_host_model_i.chain_seen, 16'h1103);
    xps_host_model_i.latch();
    exp_route[0] = 5'h15;
    check(route_map, exp_route);
    end_test("chain");
    reset_pin = 1'b1;
    repeat (5) @(negedge clock);
    reset_pin = 1'b0;
    repeat (5) @(negedge clock);
    check({drive_en, gain_x2, ctrl}, 35'h0);
    check(route_map, 80'h0);
    check({bcast, chain_out}, 7'h00);
    end_test("reset_pin");
    final_report();
  end
endmodule

// ==== verification/xps_host_model.sv ====
// host side model of the three-wire serial configuration link
// assumes the bench clock paces it; pins move only at clock falling edges
`timescale 1ns/1ps

module xps_host_model (
  input wire logic clock,
  output logic serial_clk,
  output logic serial_in,
  output logic load_strobe,
  input wire logic chain_out
);
  // ==========================================================================
  // pin state and chain capture
  // chain bits seen just before each rise, shifted in lsb first
  logic [15:0] chain_seen;

  // serial clock stands still low outside frames
  initial begin
    serial_clk = 1'b0;
    serial_in = 1'b0;
    load_strobe = 1'b0;
    chain_seen = 16'h0000;
  end

  // wait a number of clock falling edges
  task automatic gap(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic shift_word(input logic [15:0] w);
    for (int i = 0; i < 16; i++) begin
      serial_clk = 1'b0;
      serial_in = w[i];
      gap(5);
      chain_seen = {chain_out, chain_seen[15:1]};
      serial_clk = 1'b1;
      gap(5);
    end
    serial_clk = 1'b0;
    // released data shows the inverse so a stale bit never looks valid
    serial_in = ~w[15];
    gap(5);
  endtask

  // set the strobe level and let it settle
  task automatic strobe(input logic v);
    load_strobe = v;
    gap(5);
  endtask

  // one strobe pulse applies only the last shifted word
  task automatic latch();
    strobe(1'b1);
    strobe(1'b0);
  endtask
endmodule
